// [shared/bbs_pkg.sv]
// Purpose: Constants and types for the branch and bit-set execute slice.
// Assumes: 16-bit instruction words, 21-bit byte program counter, 12-bit data addresses.
// Notes:   Phase one-hot codes follow the four-phase instruction cycle.
package bbs_pkg;
  localparam int          PC_W          = 21;
  localparam int          DA_W          = 12;
  localparam logic [7:0]  OP_BZC_HI     = 8'hE1;
  localparam logic [4:0]  OP_BRA_HI     = 5'h1A;
  localparam logic [3:0]  OP_SFB_HI     = 4'h8;
  localparam logic [7:0]  IDX_LIMIT     = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT     = 8'h60;
  localparam logic [3:0]  ACC_HI_BANK   = 4'hF;
  localparam logic [PC_W-1:0] PC_RST    = 21'h000000;
  localparam logic [3:0]  BSR_RST       = 4'h0;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } bbs_phase_t;
endpackage : bbs_pkg

// [core/bbs_data_ram.sv]
// Purpose: Small data memory holding the file registers.
// Assumes: One read and one write port, registered read data.
// Notes:   Contents are not reset.
`timescale 1ns/1ps
`default_nettype none
module bbs_data_ram (
  // Clock.
  input  wire logic                      i_clk_sys,
  // Read port.
  input  wire logic [bbs_pkg::DA_W-1:0]  i_raddr,
  output logic      [7:0]                o_rdata,
  // Write port.
  input  wire logic                      i_we,
  input  wire logic [bbs_pkg::DA_W-1:0]  i_waddr,
  input  wire logic [7:0]                i_wdata
);
  import bbs_pkg::*;

  logic [7:0] mem [0:(1<<DA_W)-1];

  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : bbs_data_ram
`default_nettype wire

// [core/bbs_exec.sv]
// Purpose: Decode and execute of the zero-clear branch, relative branch and file bit set.
// Assumes: One phase per clock; an instruction word is presented with i_instr_valid.
// Notes:   Other opcodes execute as a one-cycle no-operation here.
// Behaviour
// - Zero-clear branch taken only when zero flag clear.
// - Eight-bit offset; taken two cycles, else one.
// - Relative branch always loads PC plus 2+2n.
// - Relative branch: PC written Q4, then no-op cycle.
// - Bit set: read, set bit b, write back.
// - Access bit one uses bank select register.
// - Extended mode, a=0, f<=5Fh uses indexed offset.
`timescale 1ns/1ps
`default_nettype none
module bbs_exec (
  // Clock and reset.
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  // Fetch side.
  input  wire logic [15:0]               i_instr,
  input  wire logic                      i_instr_valid,
  // Status and mode.
  input  wire logic                      i_zero_flag,
  input  wire logic                      i_ext_set_en,
  input  wire logic [3:0]                i_bank_select_register,
  input  wire logic [bbs_pkg::DA_W-1:0]  i_fsr2,
  // Outputs.
  output logic      [bbs_pkg::PC_W-1:0]  o_pc,
  output logic                           o_flush,
  output logic                           o_fetch_ack,
  output logic      [3:0]                o_phase,
  output logic                           o_wr_strobe,
  output logic      [bbs_pkg::DA_W-1:0]  o_wr_addr,
  output logic      [7:0]                o_wr_data
);
  import bbs_pkg::*;

  typedef enum logic [1:0] {
    K_NONE = 2'h0,
    K_BZC  = 2'h1,
    K_BRA  = 2'h2,
    K_SFB  = 2'h3
  } bbs_kind_t;

  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [10:0] n);
    logic [PC_W-1:0] ext;
    ext = {{(PC_W-11){n[10]}}, n};
    return pc + (ext << 1);
  endfunction : branch_target

  function automatic logic [DA_W-1:0] file_addr(input logic [7:0] f, input logic a,
                                                input logic ext_en, input logic [3:0] bank_select_register,
                                                input logic [DA_W-1:0] fsr2);
    logic [DA_W-1:0] r;
    r = {bank_select_register, f};
    if (!a) begin
      if (ext_en && (f <= IDX_LIMIT)) begin
        r = fsr2 + {4'h0, f};
      end else if (f < ACC_SPLIT) begin
        r = {4'h0, f};
      end else begin
        r = {ACC_HI_BANK, f};
      end
    end
    return r;
  endfunction : file_addr

  bbs_phase_t      ph_q, ph_d;
  bbs_kind_t       kind_q, kind_d;
  logic            nop_q, nop_d;
  logic            live_q, live_d;
  logic [15:0]     ir_q, ir_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic            flush_q, flush_d;
  logic            ack_q, ack_d;
  logic            we_q, we_d;
  logic [DA_W-1:0] wa_q, wa_d;
  logic [7:0]      wd_q, wd_d;
  logic [DA_W-1:0] ea_q, ea_d;
  logic [7:0]      rdata;

  bbs_data_ram u_ram (
    .i_clk_sys (i_clk_sys),
    .i_raddr   (ea_q),
    .o_rdata   (rdata),
    .i_we      (we_q),
    .i_waddr   (wa_q),
    .i_wdata   (wd_q)
  );

  always_comb begin
    ph_d    = ph_q;
    kind_d  = kind_q;
    nop_d   = nop_q;
    live_d  = live_q;
    ir_d    = ir_q;
    pc_d    = pc_q;
    flush_d = 1'b0;
    ack_d   = 1'b0;
    we_d    = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    ea_d    = ea_q;
    case (ph_q)
      PH_Q1: begin
        ph_d   = PH_Q2;
        live_d = 1'b0;
        if (nop_q) begin
          nop_d = 1'b0;
        end else if (i_instr_valid) begin
          live_d = 1'b1;
          ack_d  = 1'b1;
          ir_d   = i_instr;
          pc_d   = pc_q + 21'h000002;
          if (i_instr[15:8] == OP_BZC_HI) begin
            kind_d = K_BZC;
          end else if (i_instr[15:11] == OP_BRA_HI) begin
            kind_d = K_BRA;
          end else if (i_instr[15:12] == OP_SFB_HI) begin
            kind_d = K_SFB;
          end else begin
            kind_d = K_NONE;
          end
        end
      end
      PH_Q2: begin
        ph_d = PH_Q3;
        ea_d = file_addr(ir_q[7:0], ir_q[8], i_ext_set_en,
                         i_bank_select_register, i_fsr2);
      end
      PH_Q3: begin
        ph_d = PH_Q4;
      end
      PH_Q4: begin
        ph_d = PH_Q1;
        if (live_q) begin
          case (kind_q)
            K_BZC: begin
              if (!i_zero_flag) begin
                pc_d    = branch_target(pc_q, {{3{ir_q[7]}}, ir_q[7:0]});
                nop_d   = 1'b1;
                flush_d = 1'b1;
              end
            end
            K_BRA: begin
              pc_d    = branch_target(pc_q, ir_q[10:0]);
              nop_d   = 1'b1;
              flush_d = 1'b1;
            end
            K_SFB: begin
              we_d = 1'b1;
              wa_d = ea_q;
              wd_d = rdata | (8'h01 << ir_q[11:9]);
            end
            default: begin
              we_d = 1'b0;
            end
          endcase
        end
      end
      default: begin
        ph_d = PH_Q1;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q    <= PH_Q1;
      kind_q  <= K_NONE;
      nop_q   <= 1'b0;
      live_q  <= 1'b0;
      ir_q    <= 16'h0000;
      pc_q    <= PC_RST;
      flush_q <= 1'b0;
      ack_q   <= 1'b0;
      we_q    <= 1'b0;
      wa_q    <= {DA_W{1'b0}};
      wd_q    <= 8'h00;
      ea_q    <= {DA_W{1'b0}};
    end else begin
      ph_q    <= ph_d;
      kind_q  <= kind_d;
      nop_q   <= nop_d;
      live_q  <= live_d;
      ir_q    <= ir_d;
      pc_q    <= pc_d;
      flush_q <= flush_d;
      ack_q   <= ack_d;
      we_q    <= we_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
      ea_q    <= ea_d;
    end
  end

  assign o_pc        = pc_q;
  assign o_flush     = flush_q;
  assign o_fetch_ack = ack_q;
  assign o_phase     = ph_q;
  assign o_wr_strobe = we_q;
  assign o_wr_addr   = wa_q;
  assign o_wr_data   = wd_q;
endmodule : bbs_exec
`default_nettype wire

// [tb/bbs_exec_asserts.sv]
// Purpose: Concurrent checks on the branch and bit-set execute ports.
// Assumes: A word is taken at a Q1 edge outside the no-op cycle.
// Notes:   Ack and pc step are judged one edge after the take, branch and write results four edges after.
`timescale 1ns/1ps
`default_nettype none
module bbs_exec_asserts import bbs_pkg::*; (
  // Inputs of the block, with the o_phase and o_wr_addr outputs.
  input wire logic i_clk_sys, i_rst_n, i_instr_valid, i_zero_flag, i_ext_set_en,
  input wire logic [15:0] i_instr,
  input wire logic [3:0] i_bank_select_register, o_phase,
  input wire logic [DA_W-1:0] i_fsr2, o_wr_addr,
  // Outputs of the block.
  input wire logic [PC_W-1:0] o_pc,
  input wire logic o_flush, o_fetch_ack, o_wr_strobe,
  input wire logic [7:0] o_wr_data
);
  wire tk = o_phase == 4'h1 && i_instr_valid && !o_flush;
  wire bz = tk && i_instr[15:8] == OP_BZC_HI;
  wire br = tk && i_instr[15:11] == OP_BRA_HI;
  wire sf = tk && i_instr[15:12] == OP_SFB_HI;
  wire [20:0] o8 = {{12{i_instr[7]}}, i_instr[7:0], 1'b0};
  wire [20:0] o11 = {{9{i_instr[10]}}, i_instr[10:0], 1'b0};
  wire [7:0] f = i_instr[7:0];
  wire [2:0] b = i_instr[11:9];
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_take_ack: assert property (tk |=> o_fetch_ack && o_pc == $past(o_pc) + 21'h2)
    else $error("no ack or pc step after take");
  a_zero_cond: assert property (bz |-> ##4 o_flush == !$past(i_zero_flag))
    else $error("zero-clear branch decision wrong");
  a_zero_tgt: assert property (bz |-> ##4
    o_pc == $past(o_pc, 3) + (o_flush ? $past(o8, 4) : 21'h0))
    else $error("zero-clear branch pc wrong");
  a_rel_tgt: assert property (br |-> ##4
    o_flush && o_pc == $past(o_pc, 3) + $past(o11, 4))
    else $error("relative branch pc wrong");
  a_flush_noop: assert property (o_flush |-> o_phase == 4'h1 ##1 !o_fetch_ack [*4])
    else $error("word taken in no-op cycle");
  a_set_bit: assert property (sf |-> ##4
    o_wr_strobe && !o_flush && o_wr_data[$past(b, 4)])
    else $error("bit set write wrong");
  a_bank_sel: assert property (sf && i_instr[8] |-> ##4
    o_wr_addr == {$past(i_bank_select_register, 3), $past(f, 4)})
    else $error("banked address wrong");
  a_idx_mode: assert property (sf && !i_instr[8] && f <= IDX_LIMIT
    ##1 i_ext_set_en |-> ##3 o_wr_addr == $past(i_fsr2, 3) + 12'($past(f, 4)))
    else $error("indexed address wrong");
endmodule : bbs_exec_asserts
`default_nettype wire

// [tb/bbs_exec_bench.sv]
// Purpose: Self-checking bench for the execute slice.
// Assumes: Inputs change on the falling edge.
// Notes:   The expected pc is tracked here from the encodings.
`timescale 1ns/1ps
`default_nettype none
module bbs_exec_bench;
  import bbs_pkg::*;
  logic clk = 0, rst_n = 0, vld = 0, zf = 0, ext = 0, fl, ack, ws;
  logic [15:0] ins = 16'h0000;
  logic [3:0] bank_select_register = 4'h3, ph;
  logic [DA_W-1:0] fsr = 12'h100, wa;
  logic [PC_W-1:0] pc, epc;
  logic [7:0] wd;
  int num_errors = 0, total_checks = 0;
  always #25 clk = ~clk;
  bbs_exec dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_instr(ins), .i_instr_valid(vld),
    .i_zero_flag(zf), .i_ext_set_en(ext), .i_bank_select_register(bank_select_register), .i_fsr2(fsr),
    .o_pc(pc), .o_flush(fl), .o_fetch_ack(ack), .o_phase(ph), .o_wr_strobe(ws),
    .o_wr_addr(wa), .o_wr_data(wd));
  task automatic chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // Presents one word at the next usable Q1 and returns once its result stands.
  task automatic op(input logic [15:0] w);
    int n;
    n = 0;
    while ((ph !== 4'h1 || fl !== 1'b0) && n < 12) begin
      @(negedge clk);
      n++;
    end
    chk("q1_wait", 21'(n < 12), 21'h1);
    ins = w;
    vld = 1;
    @(negedge clk);
    vld = 0;
    epc = epc + 21'h2;
    chk("ack", 21'(ack), 21'h1);
    chk("pc_step", pc, epc);
    chk("phase_q2", 21'(ph), 21'h2);
    repeat (3) @(negedge clk);
    chk("phase_q1", 21'(ph), 21'h1);
  endtask : op
  task automatic t_bzc;
    op({OP_BZC_HI, 8'h80});
    epc = epc - 21'd256;
    chk("bzc_flush", 21'(fl), 21'h1);
    chk("bzc_pc", pc, epc);
    ins = {OP_BZC_HI, 8'h7F};
    vld = 1;
    @(negedge clk);
    vld = 0;
    chk("noop_ack", 21'(ack), 21'h0);
    chk("noop_pc", pc, epc);
    zf = 1;
    op({OP_BZC_HI, 8'h7F});
    chk("bzc_stay", 21'(fl), 21'h0);
    chk("bzc_stay_pc", pc, epc);
    $display("Test zero-clear branch done");
  endtask : t_bzc
  task automatic t_bra;
    op({OP_BRA_HI, 11'h3FF});
    epc = epc + 21'd2046;
    chk("bra_flush", 21'(fl), 21'h1);
    chk("bra_pc_fwd", pc, epc);
    op({OP_BRA_HI, 11'h400});
    epc = epc - 21'd2048;
    chk("bra_pc_back", pc, epc);
    op(16'h0000);
    chk("other_quiet", 21'({fl, ws}), 21'h0);
    $display("Test relative branch done");
  endtask : t_bra
  task automatic t_bsf;
    for (int b = 0; b < 8; b++) begin
      op({OP_SFB_HI, 3'(b), 1'b1, 8'h12});
      chk("bsf_bit", 21'({ws, wd[b]}), 21'h3);
      chk("bsf_addr", 21'(wa), 21'h312);
    end
    chk("bsf_keep", 21'(wd), 21'hFF);
    op({OP_SFB_HI, 3'd0, 1'b0, IDX_LIMIT});
    chk("acc_low_addr", 21'(wa), 21'h05F);
    ext = 1;
    op({OP_SFB_HI, 3'd0, 1'b0, IDX_LIMIT});
    chk("idx_addr", 21'(wa), 21'h15F);
    op({OP_SFB_HI, 3'd0, 1'b0, ACC_SPLIT});
    chk("acc_addr", 21'(wa), 21'hF60);
    $display("Test bit set done");
  endtask : t_bsf
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    epc = PC_RST;
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_bzc();
    t_bra();
    t_bsf();
    report_and_stop();
  end
  initial begin
    repeat (3000) @(negedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule : bbs_exec_bench
bind bbs_exec bbs_exec_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
  .i_instr_valid(i_instr_valid), .i_zero_flag(i_zero_flag), .i_ext_set_en(i_ext_set_en),
  .i_instr(i_instr), .i_bank_select_register(i_bank_select_register), .o_phase(o_phase),
  .i_fsr2(i_fsr2), .o_wr_addr(o_wr_addr), .o_pc(o_pc), .o_flush(o_flush),
  .o_fetch_ack(o_fetch_ack), .o_wr_strobe(o_wr_strobe), .o_wr_data(o_wr_data));
`default_nettype wire
